// ### shared/led_gs_regs.svh
// Summary of operation
// - 48-bit shifter and separate 36-bit intensity latch
// - Latch pulse with command match copies low 36
// - Command mismatch leaves latch contents untouched
// - Bits 0 to 11 drive channel 2
// - Bits 12 to 23 drive channel 1
// - Bits 24 to 35 drive channel 0
// - Bits 36 to 47 hold write command
// - First two rising edges measure bit period
// - Early second edge is one, none is zero
// - Short low hold freezes shifter, forwards input
// - Long low hold fires latch pulse
`ifndef LED_GS_REGS_SVH
`define LED_GS_REGS_SVH

`define SHIFT_W 48
`define CHAN_W 12
`define CH2_LSB 0
`define CH2_MSB 11
`define CH1_LSB 12
`define CH1_MSB 23
`define CH0_LSB 24
`define CH0_MSB 35
`define CMD_LSB 36
`define CMD_MSB 47
`define WRITE_CMD 12'h3aa
`define SHIFT_RST 48'h0
`define CHAN_RST 12'h000

// Bit period limits in ns, clock in MHz
`define CLK_MHZ 32'h14
`define BIT_MIN_NS 32'h14a
`define BIT_MAX_NS 32'h2710
`define NS_PER_US 32'h3e8
`define BIT_MIN_CYC ((`BIT_MIN_NS * `CLK_MHZ + `NS_PER_US - 32'h1) / `NS_PER_US)
`define BIT_MAX_CYC ((`BIT_MAX_NS * `CLK_MHZ) / `NS_PER_US)
`define PER_W 8
`define FRAC_NUM 4'h9
`define FRAC_DEN 4'ha

`endif

// ### shared/led_gs_pkg.sv
package led_gs_pkg;
	typedef enum logic [2:0] {
		ST_MEAS_WAIT,
		ST_MEAS,
		ST_CELL,
		ST_GAP,
		ST_FWD
	} state_t;
	typedef logic [11:0] intensity_t;
endpackage

// ### rtl/bit_sync.sv
module bit_sync (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic d,
	output logic q
);
	logic meta_ff;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule

// ### rtl/bit_fifo.sv
module bit_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
			$error("bit_fifo needs a power-of-two depth of at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ff;
	logic [AW:0] rd_ff;
	logic push;
	logic pop;

	assign in_ready = (wr_ff[AW] == rd_ff[AW]) || (wr_ff[AW-1:0] != rd_ff[AW-1:0]);
	assign out_valid = wr_ff != rd_ff;
	assign out_data = mem[rd_ff[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ff[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ff <= '0;
			rd_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= rd_ff + 1'b1;
			end
		end
	end
endmodule

// ### rtl/led_gs_packet_latch.sv
`include "led_gs_regs.svh"

module led_gs_packet_latch #(
	parameter int EOS_MULT = 4,
	parameter int LATCH_MULT = 8,
	parameter int FIFO_DEPTH = 16,
	parameter int CNT_W = 12
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic serial_input,
	output logic serial_output,
	output logic [`CHAN_W-1:0] chan0_intensity,
	output logic [`CHAN_W-1:0] chan1_intensity,
	output logic [`CHAN_W-1:0] chan2_intensity,
	output logic latch_strobe,
	output logic period_locked,
	output logic bit_dropped
);
	generate
		if (EOS_MULT < 2 || LATCH_MULT <= EOS_MULT ||
			(`BIT_MAX_CYC * LATCH_MULT) >= (1 << CNT_W) ||
			(`BIT_MAX_CYC + 1) >= (1 << `PER_W)) begin : g_bad
			$error("led_gs_packet_latch parameters out of range");
		end
	endgenerate

	localparam logic [`PER_W-1:0] MIN_CYC = `PER_W'(`BIT_MIN_CYC);
	localparam logic [`PER_W-1:0] MAX_CYC = `PER_W'(`BIT_MAX_CYC);

	logic sin_s;
	logic sin_d_ff;
	logic rise;
	led_gs_pkg::state_t state_ff;
	logic [`PER_W-1:0] cnt_ff;
	logic [`PER_W-1:0] period_ff;
	logic [`PER_W-1:0] half_ff;
	logic [`PER_W-1:0] nine_ff;
	logic [CNT_W-1:0] eos_lim_ff;
	logic [CNT_W-1:0] lat_lim_ff;
	logic [CNT_W-1:0] low_ff;
	logic got_one_ff;
	logic push_valid_ff;
	logic push_bit_ff;
	logic push_ready;
	logic drain_valid;
	logic drain_bit;
	logic drain_fire;
	logic frozen_ff;
	logic [`SHIFT_W-1:0] serial_packet_shifter_ff;
	led_gs_pkg::intensity_t chan0_ff;
	led_gs_pkg::intensity_t chan1_ff;
	led_gs_pkg::intensity_t chan2_ff;
	logic latch_pulse_ff;
	logic serial_output_ff;
	logic period_locked_ff;
	logic bit_dropped_ff;
	logic meas_ok;
	logic latch_fire;
	logic cmd_match;
	logic [11:0] cnt_x9;
	logic [11:0] cnt_nine;

	bit_sync bit_sync_i (
		.clk(ref_clk),
		.rst_b(rst_b),
		.d(serial_input),
		.q(sin_s)
	);

	bit_fifo #(
		.WIDTH(1),
		.DEPTH(FIFO_DEPTH)
	) bit_fifo_i (
		.clk(ref_clk),
		.rst_b(rst_b),
		.in_valid(push_valid_ff),
		.in_ready(push_ready),
		.in_data(push_bit_ff),
		.out_valid(drain_valid),
		.out_ready(!frozen_ff),
		.out_data(drain_bit)
	);

	assign rise = sin_s && !sin_d_ff;
	assign drain_fire = drain_valid && !frozen_ff;
	assign meas_ok = (cnt_ff >= MIN_CYC - 1'b1) && (cnt_ff < MAX_CYC);
	assign cnt_x9 = {4'h0, cnt_ff} * {8'h00, `FRAC_NUM};
	assign cnt_nine = cnt_x9 / {8'h00, `FRAC_DEN};
	assign latch_fire = (state_ff == led_gs_pkg::ST_FWD) && (low_ff == lat_lim_ff);
	assign cmd_match = serial_packet_shifter_ff[`CMD_MSB:`CMD_LSB] == `WRITE_CMD;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sin_d_ff <= 1'b0;
		end else begin
			sin_d_ff <= sin_s;
		end
	end

	// Low-time counter used for both hold detections
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			low_ff <= '0;
		end else if (sin_s) begin
			low_ff <= '0;
		end else if (low_ff != '1) begin
			low_ff <= low_ff + 1'b1;
		end
	end

	// Bit timing and sequence control
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= led_gs_pkg::ST_MEAS_WAIT;
			cnt_ff <= '0;
			got_one_ff <= 1'b0;
			push_valid_ff <= 1'b0;
			push_bit_ff <= 1'b0;
		end else begin
			push_valid_ff <= 1'b0;
			push_bit_ff <= 1'b0;
			case (state_ff)
				led_gs_pkg::ST_MEAS_WAIT: begin
					cnt_ff <= '0;
					if (rise) begin
						state_ff <= led_gs_pkg::ST_MEAS;
					end
				end
				led_gs_pkg::ST_MEAS: begin
					if (rise && meas_ok) begin
						push_valid_ff <= 1'b1;
						state_ff <= led_gs_pkg::ST_CELL;
						cnt_ff <= '0;
						got_one_ff <= 1'b0;
					end else if (rise) begin
						cnt_ff <= '0;
					end else if (cnt_ff > MAX_CYC) begin
						state_ff <= led_gs_pkg::ST_MEAS_WAIT;
					end else begin
						cnt_ff <= cnt_ff + 1'b1;
					end
				end
				led_gs_pkg::ST_CELL: begin
					cnt_ff <= cnt_ff + 1'b1;
					if (rise && cnt_ff < half_ff) begin
						got_one_ff <= 1'b1;
					end
					if (cnt_ff == nine_ff) begin
						push_valid_ff <= 1'b1;
						push_bit_ff <= got_one_ff;
						got_one_ff <= 1'b0;
						cnt_ff <= '0;
						if (!rise) begin
							state_ff <= led_gs_pkg::ST_GAP;
						end
					end
				end
				led_gs_pkg::ST_GAP: begin
					cnt_ff <= '0;
					got_one_ff <= 1'b0;
					if (rise) begin
						state_ff <= led_gs_pkg::ST_CELL;
					end else if (low_ff >= eos_lim_ff) begin
						state_ff <= led_gs_pkg::ST_FWD;
					end
				end
				led_gs_pkg::ST_FWD: begin
					cnt_ff <= '0;
					if (latch_fire) begin
						state_ff <= led_gs_pkg::ST_MEAS_WAIT;
					end
				end
				default: begin
					state_ff <= led_gs_pkg::ST_MEAS_WAIT;
					cnt_ff <= '0;
				end
			endcase
		end
	end

	// Stored bit period and derived thresholds
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			period_ff <= '0;
			half_ff <= '0;
			nine_ff <= '0;
			eos_lim_ff <= '1;
			lat_lim_ff <= '1;
			period_locked_ff <= 1'b0;
		end else if (state_ff == led_gs_pkg::ST_MEAS && rise && meas_ok) begin
			period_ff <= cnt_ff;
			half_ff <= cnt_ff >> 1;
			nine_ff <= cnt_nine[`PER_W-1:0];
			eos_lim_ff <= CNT_W'(cnt_ff) * CNT_W'(EOS_MULT);
			lat_lim_ff <= CNT_W'(cnt_ff) * CNT_W'(LATCH_MULT);
			period_locked_ff <= 1'b1;
		end else if (latch_fire) begin
			period_locked_ff <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			frozen_ff <= 1'b0;
		end else if (latch_fire) begin
			frozen_ff <= 1'b0;
		end else if (state_ff == led_gs_pkg::ST_GAP && !rise && low_ff >= eos_lim_ff) begin
			frozen_ff <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			serial_packet_shifter_ff <= `SHIFT_RST;
		end else if (drain_fire) begin
			serial_packet_shifter_ff <= {serial_packet_shifter_ff[`SHIFT_W-2:0], drain_bit};
		end
	end

	// Intensity latch
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			chan0_ff <= `CHAN_RST;
			chan1_ff <= `CHAN_RST;
			chan2_ff <= `CHAN_RST;
		end else if (latch_fire && cmd_match) begin
			chan0_ff <= serial_packet_shifter_ff[`CH0_MSB:`CH0_LSB];
			chan1_ff <= serial_packet_shifter_ff[`CH1_MSB:`CH1_LSB];
			chan2_ff <= serial_packet_shifter_ff[`CH2_MSB:`CH2_LSB];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			latch_pulse_ff <= 1'b0;
			serial_output_ff <= 1'b0;
		end else begin
			latch_pulse_ff <= latch_fire;
			serial_output_ff <= (state_ff == led_gs_pkg::ST_FWD) && sin_s;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			bit_dropped_ff <= 1'b0;
		end else if (push_valid_ff && !push_ready) begin
			bit_dropped_ff <= 1'b1;
		end
	end

	assign serial_output = serial_output_ff;
	assign chan0_intensity = chan0_ff;
	assign chan1_intensity = chan1_ff;
	assign chan2_intensity = chan2_ff;
	assign latch_strobe = latch_pulse_ff;
	assign period_locked = period_locked_ff;
	assign bit_dropped = bit_dropped_ff;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	sequence latch_ok_s;
		latch_fire && cmd_match;
	endsequence

	sequence latch_bad_s;
		latch_fire && !cmd_match;
	endsequence

	sequence cell_end_s;
		state_ff == led_gs_pkg::ST_CELL && cnt_ff == nine_ff;
	endsequence

	latch_copy_a: assert property (
		latch_ok_s |=> latch_strobe &&
			{chan0_ff, chan1_ff, chan2_ff} == $past(serial_packet_shifter_ff[`CH0_MSB:0]))
		else $error("intensity latch not loaded on matching command");

	reject_hold_a: assert property (
		latch_bad_s |=> $stable({chan0_ff, chan1_ff, chan2_ff}) && latch_strobe)
		else $error("intensity latch changed on bad command");

	quiet_latch_a: assert property (
		!latch_fire |=> $stable({chan0_ff, chan1_ff, chan2_ff}))
		else $error("intensity latch changed without latch pulse");

	chan2_map_a: assert property (
		latch_ok_s |=> chan2_intensity == $past(serial_packet_shifter_ff[`CH2_MSB:`CH2_LSB]))
		else $error("channel 2 field misplaced");

	chan1_map_a: assert property (
		latch_ok_s |=> chan1_intensity == $past(serial_packet_shifter_ff[`CH1_MSB:`CH1_LSB]))
		else $error("channel 1 field misplaced");

	chan0_map_a: assert property (
		latch_ok_s |=> chan0_intensity == $past(serial_packet_shifter_ff[`CH0_MSB:`CH0_LSB]))
		else $error("channel 0 field misplaced");

	shift_lsb_a: assert property (
		drain_fire |=> serial_packet_shifter_ff ==
			{$past(serial_packet_shifter_ff[`SHIFT_W-2:0]), $past(drain_bit)})
		else $error("bit not shifted in at bit zero");

	freeze_hold_a: assert property (
		frozen_ff |=> $stable(serial_packet_shifter_ff))
		else $error("shifter moved while frozen");

	forward_copy_a: assert property (
		state_ff == led_gs_pkg::ST_FWD |=> serial_output == $past(sin_s))
		else $error("input not forwarded");

	decode_bit_a: assert property (
		cell_end_s |=> push_valid_ff && push_bit_ff == $past(got_one_ff))
		else $error("bit not pushed at cell decision point");

	one_window_a: assert property (
		state_ff == led_gs_pkg::ST_CELL && rise && cnt_ff < half_ff && cnt_ff != nine_ff
			|=> got_one_ff)
		else $error("early edge not taken as one");

	period_range_a: assert property (
		$rose(period_locked_ff) |-> period_ff >= MIN_CYC - 1'b1 && period_ff < MAX_CYC &&
			half_ff == (period_ff >> 1))
		else $error("bit period outside allowed range");

	latch_pulse_a: assert property (
		latch_fire |=> latch_strobe ##1 !latch_strobe && state_ff == led_gs_pkg::ST_MEAS_WAIT)
		else $error("latch strobe not a single pulse");

	quiet_output_a: assert property (
		state_ff != led_gs_pkg::ST_FWD |=> !serial_output)
		else $error("output driven outside forwarding");
endmodule

// ### dv/led_host_model.sv
module led_host_model (
	output logic serial_input,
	input wire logic ref_clk
);
	timeunit 1ns;
	timeprecision 100ps;

	initial serial_input = 1'b0;

	// Level for n cycles, ends just after an edge
	task automatic drive(input logic v, input int n);
		serial_input = v;
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// Measurement pair carries bit 47 as zero, then 46 down to 0
	task automatic send_packet(input logic [47:0] pkt, input int per);
		int i;
		@(posedge ref_clk);
		#1;
		drive(1'b1, 3);
		drive(1'b0, per - 3);
		for (i = 46; i >= 0; i--) begin
			if (pkt[i]) begin
				drive(1'b1, 1);
				drive(1'b0, 1);
				drive(1'b1, 2);
				drive(1'b0, per - 4);
			end else begin
				drive(1'b1, 3);
				drive(1'b0, per - 3);
			end
		end
	endtask
endmodule

// ### dv/led_gs_packet_latch_tb_top.sv
`include "led_gs_regs.svh"

module led_gs_packet_latch_tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic ref_clk;
	logic rst_b;
	logic serial_input;
	logic serial_output;
	logic [11:0] chan0_intensity;
	logic [11:0] chan1_intensity;
	logic [11:0] chan2_intensity;
	logic latch_strobe;
	logic period_locked;
	logic bit_dropped;
	int miscompares;
	int n_checks;

	led_gs_packet_latch led_gs_packet_latch_i (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.serial_input(serial_input),
		.serial_output(serial_output),
		.chan0_intensity(chan0_intensity),
		.chan1_intensity(chan1_intensity),
		.chan2_intensity(chan2_intensity),
		.latch_strobe(latch_strobe),
		.period_locked(period_locked),
		.bit_dropped(bit_dropped)
	);

	led_host_model led_host_model_i (
		.serial_input(serial_input),
		.ref_clk(ref_clk)
	);

	always #25 ref_clk = ~ref_clk;

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		if (miscompares == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic check_chans(input logic [47:0] pkt);
		check({36'h0, chan0_intensity}, {36'h0, pkt[35:24]});
		check({36'h0, chan1_intensity}, {36'h0, pkt[23:12]});
		check({36'h0, chan2_intensity}, {36'h0, pkt[11:0]});
	endtask

	// Line already low; strobe must come after the long low hold
	task automatic wait_strobe(input int per);
		int n;
		n = 0;
		while (latch_strobe !== 1'b1 && n < 12 * per) begin
			cyc(1);
			n++;
		end
		check({47'h0, latch_strobe}, 48'h1);
		check({47'h0, n >= 6 * per}, 48'h1);
		cyc(2);
		check({47'h0, latch_strobe}, 48'h0);
	endtask

	task automatic t_reset();
		check_chans(48'h0);
		check({44'h0, latch_strobe, period_locked, serial_output, bit_dropped}, 48'h0);
	endtask

	task automatic t_good_forward();
		logic [47:0] pkt;
		pkt = {`WRITE_CMD, 12'ha5c, 12'h3c1, 12'hf0f};
		led_host_model_i.send_packet(pkt, 20);
		check({47'h0, period_locked}, 48'h1);
		check({47'h0, serial_output}, 48'h0);
		led_host_model_i.drive(1'b0, 100);
		led_host_model_i.drive(1'b1, 6);
		check({47'h0, serial_output}, 48'h1);
		led_host_model_i.drive(1'b0, 5);
		check({47'h0, serial_output}, 48'h0);
		wait_strobe(20);
		check_chans(pkt);
		check({47'h0, period_locked}, 48'h0);
	endtask

	task automatic t_bad_cmd();
		logic [47:0] old;
		old = {`WRITE_CMD, 12'ha5c, 12'h3c1, 12'hf0f};
		led_host_model_i.send_packet({12'h3ab, 12'h123, 12'h456, 12'h789}, 10);
		wait_strobe(10);
		check_chans(old);
	endtask

	task automatic t_fast_edges();
		logic [47:0] pkt;
		pkt = {`WRITE_CMD, 12'h001, 12'h800, 12'hffe};
		led_host_model_i.send_packet(pkt, 7);
		wait_strobe(7);
		check_chans(pkt);
		check({47'h0, bit_dropped}, 48'h0);
	endtask

	// Reset in mid-run, then a pair of rises too close to be a period
	task automatic t_mid_reset();
		rst_b = 1'b0;
		cyc(2);
		rst_b = 1'b1;
		cyc(2);
		t_reset();
		led_host_model_i.drive(1'b1, 2);
		led_host_model_i.drive(1'b0, 2);
		led_host_model_i.drive(1'b1, 2);
		led_host_model_i.drive(1'b0, 10);
		check({47'h0, period_locked}, 48'h0);
	endtask

	initial begin
		ref_clk = 1'b0;
		rst_b = 1'b0;
		miscompares = 0;
		n_checks = 0;
		cyc(2);
		rst_b = 1'b1;
		cyc(2);
		t_reset();
		t_good_forward();
		t_bad_cmd();
		t_fast_edges();
		t_mid_reset();
		summarize();
	end

	initial begin
		#2ms;
		miscompares++;
		summarize();
	end
endmodule
